/* scc_chan_ctrl.sv */
module scc_chan_ctrl (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  input wire logic [4:0] port_addr_i,
  input wire logic channel_sleep_pin_n_i,
  input wire logic [2:0] lane_speed_pins_i,
  input wire logic [1:0] automatic_speed_detect_en_i,
  input wire scc_pkg::scc_rate_type asd_rate_i,
  input wire scc_pkg::scc_rate_type pin_rate_i,
  output scc_pkg::scc_ctrl_type ctrl_o
);

  typedef enum logic [2:0] {
    ST_PRE,
    ST_START,
    ST_OP,
    ST_ADDR,
    ST_TA,
    ST_DATA
  } scc_frame_type;

  scc_frame_type state_q;
  logic mdc_prev_q;
  logic [5:0] cnt_q;
  logic [15:0] sh_q;
  logic [1:0] op_q;
  logic [9:0] addr_q;
  logic hit_q;
  logic wr_en_q;
  logic [15:0] wr_data_q;
  logic mdio_q;
  logic oe_q;
  logic [15:0] rd_data;

  // Mdc is sampled on the system clock, so it must run at no more than half its rate.
  wire rise = mdc_i && !mdc_prev_q;
  wire [9:0] addr_next = {addr_q[8:0], mdio_i};
  wire addr_hit = (addr_next[9:5] == port_addr_i) && (addr_next[4:0] == scc_pkg::REG_ADDR);
  wire pre_full = cnt_q >= 6'(scc_pkg::PREAMBLE_ONES);
  wire [1:0] op_next = {op_q[0], mdio_i};
  wire op_ok = (op_next == scc_pkg::OP_READ) || (op_next == scc_pkg::OP_WRITE);
  wire is_read = op_q == scc_pkg::OP_READ;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mdc_prev_q <= 1'h0;
    end else begin
      mdc_prev_q <= mdc_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_PRE;
      cnt_q <= 6'h00;
      sh_q <= 16'h0000;
      op_q <= 2'h0;
      addr_q <= 10'h000;
      hit_q <= 1'h0;
      wr_en_q <= 1'h0;
      wr_data_q <= 16'h0000;
      mdio_q <= 1'h1;
      oe_q <= 1'h0;
    end else begin
      wr_en_q <= 1'h0;
      if (rise) begin
        unique case (state_q)
          ST_PRE: begin
            if (mdio_i) begin
              cnt_q <= pre_full ? cnt_q : cnt_q + 6'h01;
            end else begin
              cnt_q <= 6'h00;
              state_q <= pre_full ? ST_START : ST_PRE;
            end
          end
          ST_START: begin
            state_q <= mdio_i ? ST_OP : ST_PRE;
            cnt_q <= 6'h00;
          end
          ST_OP: begin
            op_q <= op_next;
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'h01) begin
              state_q <= op_ok ? ST_ADDR : ST_PRE;
              cnt_q <= 6'h00;
            end
          end
          ST_ADDR: begin
            addr_q <= addr_next;
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'h09) begin
              state_q <= ST_TA;
              cnt_q <= 6'h00;
              hit_q <= addr_hit;
              sh_q <= rd_data;
            end
          end
          ST_TA: begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'h00 && is_read && hit_q) begin
              oe_q <= 1'h1;
              mdio_q <= 1'h0;
            end
            if (cnt_q == 6'h01) begin
              state_q <= ST_DATA;
              cnt_q <= 6'h00;
              if (is_read && hit_q) begin
                mdio_q <= sh_q[15];
                sh_q <= {sh_q[14:0], 1'h0};
              end
            end
          end
          // A frame for another port is still clocked through, so the hunt for the
          // next preamble starts only after its last data bit.
          ST_DATA: begin
            cnt_q <= cnt_q + 6'h01;
            if (is_read) begin
              mdio_q <= sh_q[15];
              sh_q <= {sh_q[14:0], 1'h0};
            end else begin
              sh_q <= {sh_q[14:0], mdio_i};
            end
            if (cnt_q == 6'h0f) begin
              state_q <= ST_PRE;
              cnt_q <= 6'h00;
              oe_q <= 1'h0;
              mdio_q <= 1'h1;
              wr_en_q <= !is_read && hit_q;
              wr_data_q <= {sh_q[14:0], mdio_i};
            end
          end
        endcase
      end
    end
  end

  assign mdio_o = mdio_q;
  assign mdio_oe_o = oe_q;

  scc_chan_core u_core (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(wr_en_q),
    .wr_data_i(wr_data_q),
    .channel_sleep_pin_n_i(channel_sleep_pin_n_i),
    .lane_speed_pins_i(lane_speed_pins_i),
    .automatic_speed_detect_en_i(automatic_speed_detect_en_i),
    .asd_rate_i(asd_rate_i),
    .pin_rate_i(pin_rate_i),
    .ctrl_o(ctrl_o),
    .rd_data_o(rd_data)
  );

  wire asd_on = automatic_speed_detect_en_i != scc_pkg::ASD_OFF;
  wire sw_mode = (lane_speed_pins_i == scc_pkg::PINS_SOFTWARE) && !asd_on;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // A write lands in the core one clock after its strobe and reaches the applied
  // settings one clock later still, so the checks look one or two clocks back.
  sleep_write_a: assert property (
    wr_en_q |=> rd_data[15] == $past(wr_data_q[15]))
    else $error("sleep bit did not take the written value");
  sleep_or_a: assert property (
    ctrl_o.channel_sleep == $past(rd_data[15] | !channel_sleep_pin_n_i))
    else $error("effective sleep is not bit OR inverted pin");
  filter_legal_a: assert property (
    wr_en_q && wr_data_q[9:8] inside {2'h1, 2'h2} |=> rd_data[9:8] == $past(wr_data_q[9:8]))
    else $error("legal filter code was not taken");
  filter_reserved_a: assert property (
    wr_en_q && wr_data_q[9:8] inside {2'h0, 2'h3} |=> $stable(rd_data[9:8]))
    else $error("reserved filter code was accepted");
  tx_sw_a: assert property (
    wr_en_q && sw_mode ##1 sw_mode |=> ctrl_o.rate.tx_rate == $past(wr_data_q[7:6], 2))
    else $error("written transmit rate not applied");
  rx_sw_a: assert property (
    wr_en_q && sw_mode ##1 sw_mode |=> ctrl_o.rate.rx_rate == $past(wr_data_q[5:4], 2))
    else $error("written receive rate not applied");
  ratio_sw_a: assert property (
    wr_en_q && sw_mode ##1 sw_mode |=> ctrl_o.rate.pll_ratio == $past(wr_data_q[3:0], 2))
    else $error("written ratio not applied");
  pin_mode_a: assert property (
    !sw_mode && !asd_on |=> {ctrl_o.rate.tx_rate, ctrl_o.rate.rx_rate} ==
                            $past({pin_rate_i.tx_rate, pin_rate_i.rx_rate}))
    else $error("written rate used outside software mode");
  asd_rate_a: assert property (
    asd_on |=> ctrl_o.rate == $past(asd_rate_i))
    else $error("detect mode rates not applied");
  rate_read_a: assert property (
    !sw_mode |=> rd_data[7:4] == $past(asd_on ? {asd_rate_i.tx_rate, asd_rate_i.rx_rate}
                                               : {pin_rate_i.tx_rate, pin_rate_i.rx_rate}))
    else $error("rate read does not show applied rate");
  ratio_asd_a: assert property (
    asd_on ##1 asd_on |-> rd_data[3:0] == $past(asd_rate_i.pll_ratio))
    else $error("ratio read does not show detect value");
  read_drive_a: assert property (
    $rose(mdio_oe_o) |-> is_read && hit_q)
    else $error("data line driven outside an own read frame");
  reserved_zero_a: assert property (
    rd_data[14:10] == scc_pkg::RSVD_RESET)
    else $error("reserved bits changed");

  sw_write_c: cover property (wr_en_q && sw_mode);
  read_frame_c: cover property ($rose(mdio_oe_o) ##[1:1000] $fell(mdio_oe_o));
  asd_write_c: cover property (wr_en_q && asd_on);
  filter_refuse_c: cover property (wr_en_q && wr_data_q[9:8] == 2'h3);
  pin_mode_c: cover property (!sw_mode && !asd_on && pin_rate_i.tx_rate != 2'h0);

endmodule // scc_chan_ctrl

/* scc_pkg.sv */
package scc_pkg;

  // Register location on the management serial interface.
  localparam logic [4:0] REG_ADDR = 5'h01;

  // Field positions inside the channel control register.
  localparam int SLEEP_BIT = 15;
  localparam int RSVD_HI = 14;
  localparam int RSVD_LO = 10;
  localparam int FILT_HI = 9;
  localparam int FILT_LO = 8;
  localparam int TX_HI = 7;
  localparam int TX_LO = 6;
  localparam int RX_HI = 5;
  localparam int RX_LO = 4;
  localparam int RATIO_HI = 3;
  localparam int RATIO_LO = 0;

  // Reset values of the fields.
  localparam logic [15:0] REG_RESET = 16'h010d;
  localparam logic SLEEP_RESET = 1'h0;
  localparam logic [1:0] FILT_RESET = 2'h1;
  localparam logic [1:0] RATE_RESET = 2'h0;
  localparam logic [3:0] RATIO_RESET = 4'hd;
  localparam logic [4:0] RSVD_RESET = 5'h00;

  // Filter codes and rate codes.
  localparam logic [1:0] FILT_NO_CLEANER = 2'h1;
  localparam logic [1:0] FILT_CLEANER = 2'h2;
  localparam logic [1:0] RATE_FULL = 2'h0;
  localparam logic [1:0] RATE_HALF = 2'h1;
  localparam logic [1:0] RATE_QUARTER = 2'h2;
  localparam logic [1:0] RATE_EIGHTH = 2'h3;

  // Pin and detect-enable values that hand rate control to software.
  localparam logic [2:0] PINS_SOFTWARE = 3'h4;
  localparam logic [1:0] ASD_OFF = 2'h0;

  // Management frame constants.
  localparam int PREAMBLE_ONES = 32;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;

  typedef struct packed {
    logic [1:0] tx_rate;
    logic [1:0] rx_rate;
    logic [3:0] pll_ratio;
  } scc_rate_type;

  typedef struct packed {
    logic channel_sleep;
    logic [1:0] pll_filter;
    scc_rate_type rate;
  } scc_ctrl_type;

endpackage

/* scc_chan_core.sv */
module scc_chan_core (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic wr_en_i,
  input wire logic [15:0] wr_data_i,
  input wire logic channel_sleep_pin_n_i,
  input wire logic [2:0] lane_speed_pins_i,
  input wire logic [1:0] automatic_speed_detect_en_i,
  input wire scc_pkg::scc_rate_type asd_rate_i,
  input wire scc_pkg::scc_rate_type pin_rate_i,
  output scc_pkg::scc_ctrl_type ctrl_o,
  output logic [15:0] rd_data_o
);

  logic sleep_q;
  logic [1:0] filt_q;
  logic [1:0] tx_q;
  logic [1:0] rx_q;
  logic [3:0] ratio_q;
  scc_pkg::scc_ctrl_type ctrl_q;
  scc_pkg::scc_ctrl_type ctrl_d;

  wire asd_active = automatic_speed_detect_en_i != scc_pkg::ASD_OFF;
  wire sw_rates = (lane_speed_pins_i == scc_pkg::PINS_SOFTWARE) && !asd_active;
  wire [1:0] wr_filt = wr_data_i[scc_pkg::FILT_HI:scc_pkg::FILT_LO];
  // Reserved filter codes would detune the loop, so such a write keeps the old code.
  wire filt_ok = (wr_filt == scc_pkg::FILT_NO_CLEANER) || (wr_filt == scc_pkg::FILT_CLEANER);
  wire rate_wr = wr_en_i && !asd_active;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sleep_q <= scc_pkg::SLEEP_RESET;
      filt_q <= scc_pkg::FILT_RESET;
      tx_q <= scc_pkg::RATE_RESET;
      rx_q <= scc_pkg::RATE_RESET;
      ratio_q <= scc_pkg::RATIO_RESET;
    end else begin
      if (wr_en_i) begin
        sleep_q <= wr_data_i[scc_pkg::SLEEP_BIT];
      end
      if (wr_en_i && filt_ok) begin
        filt_q <= wr_filt;
      end
      if (rate_wr) begin
        tx_q <= wr_data_i[scc_pkg::TX_HI:scc_pkg::TX_LO];
        rx_q <= wr_data_i[scc_pkg::RX_HI:scc_pkg::RX_LO];
        ratio_q <= wr_data_i[scc_pkg::RATIO_HI:scc_pkg::RATIO_LO];
      end
    end
  end

  always_comb begin
    ctrl_d.channel_sleep = sleep_q | ~channel_sleep_pin_n_i;
    ctrl_d.pll_filter = filt_q;
    if (asd_active) begin
      ctrl_d.rate = asd_rate_i;
    end else if (sw_rates) begin
      ctrl_d.rate = '{tx_rate: tx_q, rx_rate: rx_q, pll_ratio: ratio_q};
    end else begin
      ctrl_d.rate = '{tx_rate: pin_rate_i.tx_rate, rx_rate: pin_rate_i.rx_rate,
                      pll_ratio: ratio_q};
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_q <= '{channel_sleep: scc_pkg::SLEEP_RESET, pll_filter: scc_pkg::FILT_RESET,
                  rate: '{tx_rate: scc_pkg::RATE_RESET, rx_rate: scc_pkg::RATE_RESET,
                          pll_ratio: scc_pkg::RATIO_RESET}};
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign ctrl_o = ctrl_q;
  // Rate and ratio reads show what the serdes really uses; sleep and filter reads show the stored bits, without the sleep pin.
  assign rd_data_o = {sleep_q, scc_pkg::RSVD_RESET, filt_q, ctrl_q.rate.tx_rate,
                      ctrl_q.rate.rx_rate, ctrl_q.rate.pll_ratio};

endmodule // scc_chan_core

/* scc_mdio_station.sv */
module scc_mdio_station (
  input wire logic clk_i,
  input wire logic mdio_i,
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    mdc_o = 1'h0;
    mdio_o = 1'h1;
    mdio_oe_o = 1'h0;
  end

  // Each half of a management clock spans two system clocks, twice the one-clock minimum the device samples.
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [15:0] wd,
      output logic [15:0] rd);
    logic [63:0] bits;
    rd = 16'h0000;
    bits = {32'hffffffff, 2'h1, op, pa, scc_pkg::REG_ADDR, 2'h2, wd};
    for (int i = 63; i >= 0; i--) begin
      @(posedge clk_i);
      mdc_o <= 1'h0;
      mdio_oe_o <= !(op == scc_pkg::OP_READ && i < 18);
      mdio_o <= bits[i];
      @(posedge clk_i);
      @(negedge clk_i);
      if (i < 16) begin
        rd[i] = mdio_i;
      end
      @(posedge clk_i);
      mdc_o <= 1'h1;
      @(posedge clk_i);
    end
    @(posedge clk_i);
    mdc_o <= 1'h0;
    mdio_oe_o <= 1'h0;
    repeat (4) @(posedge clk_i);
  endtask
endmodule // scc_mdio_station

/* scc_chan_ctrl_bench.sv */
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
module scc_chan_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [4:0] PA = 5'h05;
  logic clk, rst_b, mdc, st_d, st_oe, dev_d, dev_oe, pin_n;
  logic [2:0] pins;
  logic [1:0] asd_en;
  scc_pkg::scc_rate_type asd_rate, pin_rate;
  scc_pkg::scc_ctrl_type ctrl;
  logic [15:0] rd;
  int num_errors = 0;
  int num_checks = 0;
  // The line has a pull-up, so it reads high once both ends let go.
  wire logic mdio_pin = dev_oe ? dev_d : (st_oe ? st_d : 1'h1);

  scc_mdio_station i_scc_mdio_station (.clk_i(clk), .mdio_i(mdio_pin), .mdc_o(mdc),
    .mdio_o(st_d), .mdio_oe_o(st_oe));
  scc_chan_ctrl i_scc_chan_ctrl (.clk_i(clk), .rst_b_i(rst_b), .mdc_i(mdc), .mdio_i(mdio_pin),
    .mdio_o(dev_d), .mdio_oe_o(dev_oe), .port_addr_i(PA), .channel_sleep_pin_n_i(pin_n),
    .lane_speed_pins_i(pins), .automatic_speed_detect_en_i(asd_en), .asd_rate_i(asd_rate),
    .pin_rate_i(pin_rate), .ctrl_o(ctrl));

  task automatic wr(input logic [15:0] d, input logic [4:0] pa = PA);
    i_scc_mdio_station.frame(scc_pkg::OP_WRITE, pa, d, rd);
  endtask

  task automatic rdc(input logic [15:0] e);
    i_scc_mdio_station.frame(scc_pkg::OP_READ, PA, 16'h0000, rd);
    `CHK("read", e, rd)
  endtask

  task automatic t_reset;
    `CHK("ctrl", 11'h10d, ctrl)
    rdc(16'h010d);
    $display("done reset");
  endtask

  task automatic t_software;
    wr(16'hfe7a);
    `CHK("ctrl", 11'h67a, ctrl)
    rdc(16'h827a);
    wr(16'h0300);
    rdc(16'h0200);
    $display("done software");
  endtask

  task automatic t_sleep_pin;
    @(posedge clk) pin_n <= 1'h0;
    repeat (3) @(posedge clk);
    `CHK("sleep", 1'h1, ctrl.channel_sleep)
    rdc(16'h0200);
    @(posedge clk) pin_n <= 1'h1;
    repeat (3) @(posedge clk);
    `CHK("sleep", 1'h0, ctrl.channel_sleep)
    $display("done sleep pin");
  endtask

  task automatic t_detect;
    @(posedge clk) asd_en <= 2'h1;
    asd_rate <= 8'he5;
    wr(16'h01c6);
    `CHK("rate", 8'he5, ctrl.rate)
    rdc(16'h01e5);
    @(posedge clk) asd_en <= 2'h0;
    rdc(16'h0100);
    $display("done detect");
  endtask

  task automatic t_pins;
    @(posedge clk) pins <= 3'h0;
    pin_rate <= 8'h6f;
    wr(16'h8000, PA + 5'h01);
    rdc(16'h0160);
    `CHK("rate", 8'h60, ctrl.rate)
    $display("done pins");
  endtask

  task automatic t_refused;
    i_scc_mdio_station.frame(2'h3, PA, 16'h8000, rd);
    i_scc_mdio_station.frame(scc_pkg::OP_READ, PA + 5'h01, 16'h0000, rd);
    `CHK("foreign read", 16'hffff, rd)
    rdc(16'h0160);
    $display("done refused");
  endtask

  task automatic t_midreset;
    wr(16'h8200);
    `CHK("sleep", 1'h1, ctrl.channel_sleep)
    @(posedge clk) rst_b <= 1'h0;
    pins <= scc_pkg::PINS_SOFTWARE;
    repeat (2) @(posedge clk);
    `CHK("ctrl", 11'h10d, ctrl)
    rst_b <= 1'h1;
    rdc(16'h010d);
    $display("done mid reset");
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test();
  end

  initial begin
    rst_b = 1'h0;
    pin_n = 1'h1;
    pins = scc_pkg::PINS_SOFTWARE;
    asd_en = scc_pkg::ASD_OFF;
    asd_rate = 8'h00;
    pin_rate = 8'h00;
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    t_reset();
    t_software();
    t_sleep_pin();
    t_detect();
    t_pins();
    t_refused();
    t_midreset();
    stop_test();
  end
endmodule // scc_chan_ctrl_bench
